// >>> rtl/nmt_pkg.sv
// Shared constants for the nibble move and table read executor
`default_nettype none
package nmt_pkg;
    // Widths
    localparam int NW_W   = 4;
    localparam int RA_W   = 7;
    localparam int WS_W   = 4;
    localparam int ROM_AW = 11;
    localparam int REG_AW = 3;
    localparam int REG_DW = 16;
    localparam int RAM_DEPTH = 128;
    localparam int WR_DEPTH  = 16;

    // Opcode prefixes, instr[15:7] for the 9-bit group
    localparam logic [8:0] OPC_READ_FLAGS = 9'h09e;  // 0100_1111_0
    localparam logic [8:0] OPC_LOAD_LOW   = 9'h130;  // 1001_1000_0
    localparam logic [8:0] OPC_LOAD_HIGH  = 9'h131;  // 1001_1000_1
    localparam logic [8:0] OPC_PTR_READ   = 9'h132;  // 1001_1001_0
    localparam logic [8:0] OPC_OR_ACC     = 9'h068;  // 0011_0100_0
    // instr[15:12] and instr[15:11] prefixes
    localparam logic [3:0] OPC_W_TO_M     = 4'h7;    // 0111
    localparam logic [4:0] OPC_M_TO_W     = 5'h0d;   // 0110_1
    localparam logic [4:0] OPC_IMM_READ   = 5'h15;   // 1010_1
    localparam logic [15:0] OPC_IDLE      = 16'h0000;

    // Register map (index on the plain register port)
    localparam logic [2:0] REG_STATUS  = 3'h0;
    localparam logic [2:0] REG_IRQ_EN  = 3'h1;
    localparam logic [2:0] REG_IRQ_CLR = 3'h2;
    localparam logic [2:0] REG_CORE    = 3'h3;
    localparam logic [2:0] REG_CTRL    = 3'h4;

    // Field positions
    localparam int CORE_ACC_LSB  = 0;
    localparam int CORE_TABLE_POINTER_LOW_LSB = 4;
    localparam int CORE_TABLE_POINTER_HIGH_LSB = 8;
    localparam int CORE_ZF_BIT   = 12;
    localparam int CTRL_RUN_BIT  = 0;

    // Reset values
    localparam logic [3:0] RST_NIBBLE = 4'h0;
    localparam logic       RST_ZF     = 1'b0;
    localparam logic       RST_RUN    = 1'b1;
    localparam logic [3:0] RST_IRQ_EN = 4'h0;

    typedef enum logic [1:0] {
        NMT_ST_IDLE  = 2'b00,
        NMT_ST_EXEC  = 2'b01,
        NMT_ST_TBL_A = 2'b11,
        NMT_ST_TBL_B = 2'b10
    } nmt_state_t;

    typedef enum logic [3:0] {
        NMT_OP_IDLE, NMT_OP_READ_FLAGS, NMT_OP_W_TO_M, NMT_OP_M_TO_W,
        NMT_OP_LOAD_LOW, NMT_OP_LOAD_HIGH, NMT_OP_PTR_READ,
        NMT_OP_IMM_READ, NMT_OP_OR_ACC
    } nmt_op_t;

    // Shared opcode decode; unknown codes run as idle
    function automatic nmt_op_t nmt_decode(input logic [15:0] ins);
        nmt_op_t op;
        op = NMT_OP_IDLE;
        if (ins[15:7] == OPC_READ_FLAGS) op = NMT_OP_READ_FLAGS;
        else if (ins[15:7] == OPC_LOAD_LOW) op = NMT_OP_LOAD_LOW;
        else if (ins[15:7] == OPC_LOAD_HIGH) op = NMT_OP_LOAD_HIGH;
        else if (ins[15:7] == OPC_PTR_READ) op = NMT_OP_PTR_READ;
        else if (ins[15:7] == OPC_OR_ACC) op = NMT_OP_OR_ACC;
        else if (ins[15:12] == OPC_W_TO_M) op = NMT_OP_W_TO_M;
        else if (ins[15:11] == OPC_M_TO_W) op = NMT_OP_M_TO_W;
        else if (ins[15:11] == OPC_IMM_READ) op = NMT_OP_IMM_READ;
        return op;
    endfunction
endpackage
`default_nettype wire

// >>> rtl/nmt_nibble_mem.sv
// Two-port nibble memory, separate read and write addresses, with registered read data
`default_nettype none
module nmt_nibble_mem #(
    parameter int DEPTH = 16,
    parameter int AW    = 4
) (
    input  wire logic          mclk_i,
    input  wire logic          ce_i,
    input  wire logic          rd_i,
    input  wire logic [AW-1:0] raddr_i,
    input  wire logic          we_i,
    input  wire logic [AW-1:0] waddr_i,
    input  wire logic [3:0]    wdata_i,
    output logic      [3:0]    rdata_o
);
    logic [3:0] mem_r [DEPTH];

    // No reset on the array; contents are undefined until written
    always_ff @(posedge mclk_i) begin
        if (ce_i && we_i) begin
            mem_r[waddr_i] <= wdata_i;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (ce_i && rd_i) begin
            rdata_o <= mem_r[raddr_i];
        end
    end
endmodule // nmt_nibble_mem
`default_nettype wire

// >>> rtl/nmt_change_flags.sv
// Per-pin signal change flags of the change-sense port
`default_nettype none
module nmt_change_flags
    import nmt_pkg::*;
(
    input  wire logic            mclk_i,
    input  wire logic            reset_i,
    input  wire logic            ce_i,
    input  wire logic [NW_W-1:0] change_sense_port_i,
    input  wire logic [NW_W-1:0] clear_i,
    output logic      [NW_W-1:0] port_change_flags_o
);
    logic [NW_W-1:0] sync1_r;
    logic [NW_W-1:0] sync2_r;
    logic [NW_W-1:0] prev_r;
    logic [NW_W-1:0] change;

    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            sync1_r <= RST_NIBBLE;
            sync2_r <= RST_NIBBLE;
            prev_r  <= RST_NIBBLE;
        end else if (ce_i) begin
            sync1_r <= change_sense_port_i;
            sync2_r <= sync1_r;
            prev_r  <= sync2_r;
        end
    end

    assign change = sync2_r ^ prev_r;

    // Set beats clear so a change in the clear cycle is kept
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            port_change_flags_o <= RST_NIBBLE;
        end else if (ce_i) begin
            port_change_flags_o <= (port_change_flags_o & ~clear_i) | change;
        end
    end

    a_flag_on_change: assert property (@(posedge mclk_i) disable iff (reset_i)
        (ce_i && |change) |=> ((port_change_flags_o & $past(change)) == $past(change)))
        else $error("change flag not set after pin change");
    a_flag_holds: assert property (@(posedge mclk_i) disable iff (reset_i)
        (ce_i && change == 4'h0 && clear_i == 4'h0) |=> $stable(port_change_flags_o))
        else $error("change flag moved without change or clear");
endmodule // nmt_change_flags
`default_nettype wire

// >>> rtl/nmt_exec.sv
// Executor for nibble moves, pointer loads, table reads, OR and idle
// Notes on behaviour
// - Port-flag read copies flags to accumulator, RAM
// - One sticky change flag per sense pin
// - Working register to accumulator and RAM
// - RAM nibble to working register, accumulator
// - RAM nibble loads table pointer low
// - RAM nibble loads table pointer high
// - Pointer table read, two cycles, into RAM
// - Immediate table read into working register
// - OR RAM into accumulator, RAM untouched
// - Seven address bits select one RAM nibble
`default_nettype none
module nmt_exec
    import nmt_pkg::*;
(
    input  wire logic              mclk_i,
    input  wire logic              reset_i,
    input  wire logic              ce_i,
    input  wire logic [15:0]       instr_i,
    input  wire logic              instr_valid_i,
    output logic                   instr_ready_o,
    output logic                   instr_done_o,
    output logic [ROM_AW-1:0]      rom_addr_o,
    output logic                   rom_rd_o,
    input  wire logic [NW_W-1:0]   rom_data_i,
    input  wire logic [NW_W-1:0]   change_sense_port_i,
    output logic [NW_W-1:0]        accumulator_o,
    output logic                   zero_flag_o,
    output logic [NW_W-1:0]        table_pointer_low_o,
    output logic [NW_W-1:0]        table_pointer_high_o,
    input  wire logic [REG_AW-1:0] reg_addr_i,
    input  wire logic [REG_DW-1:0] reg_wdata_i,
    input  wire logic              reg_wr_i,
    input  wire logic              reg_rd_i,
    output logic [REG_DW-1:0]      reg_rdata_o,
    output logic                   irq_o
);
    nmt_state_t      state_r;
    nmt_state_t      state_nxt;
    nmt_op_t         op_r;
    logic [15:0]     ins_r;
    logic            take;
    logic            run_r;
    logic [NW_W-1:0] irq_en_r;
    logic [NW_W-1:0] irq_clr;
    logic [NW_W-1:0] flags;
    logic [NW_W-1:0] ram_rdata;
    logic [NW_W-1:0] wr_rdata;
    logic            ram_we;
    logic [NW_W-1:0] ram_wdata;
    logic            wr_we;
    logic [WS_W-1:0] wr_waddr;
    logic [NW_W-1:0] wr_wdata;
    logic            acc_we;
    logic [NW_W-1:0] acc_wdata;

    assign take          = (state_r == NMT_ST_IDLE) && run_r && ce_i && instr_valid_i;
    assign instr_ready_o = (state_r == NMT_ST_IDLE) && run_r && ce_i;

    // Sequencer: one machine cycle is two clocks, table reads take four
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            NMT_ST_IDLE: begin
                if (take) begin
                    state_nxt = NMT_ST_EXEC;
                end
            end
            NMT_ST_EXEC: begin
                if (op_r == NMT_OP_PTR_READ || op_r == NMT_OP_IMM_READ) begin
                    state_nxt = NMT_ST_TBL_A;
                end else begin
                    state_nxt = NMT_ST_IDLE;
                end
            end
            NMT_ST_TBL_A: state_nxt = NMT_ST_TBL_B;
            NMT_ST_TBL_B: state_nxt = NMT_ST_IDLE;
            default:      state_nxt = NMT_ST_IDLE;
        endcase
    end

    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            state_r <= NMT_ST_IDLE;
        end else if (ce_i) begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            ins_r <= OPC_IDLE;
            op_r  <= NMT_OP_IDLE;
        end else if (take) begin
            ins_r <= instr_i;
            op_r  <= nmt_decode(instr_i);
        end
    end

    // ROM address registered in the execute clock; it holds through the read
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            rom_addr_o <= '0;
            rom_rd_o   <= 1'b0;
        end else if (ce_i) begin
            rom_rd_o <= 1'b0;
            if (state_r == NMT_ST_EXEC && op_r == NMT_OP_PTR_READ) begin
                rom_addr_o <= {3'h0, table_pointer_high_o, table_pointer_low_o};
                rom_rd_o   <= 1'b1;
            end else if (state_r == NMT_ST_EXEC && op_r == NMT_OP_IMM_READ) begin
                rom_addr_o <= {ins_r[6:0], accumulator_o};
                rom_rd_o   <= 1'b1;
            end
        end
    end

    // Data RAM: 7-bit direct address from the low instruction bits
    nmt_nibble_mem #(
        .DEPTH (RAM_DEPTH),
        .AW    (RA_W)
    ) u_ram (
        .mclk_i  (mclk_i),
        .ce_i    (ce_i),
        .rd_i    (take),
        .raddr_i (instr_i[6:0]),
        .we_i    (ram_we),
        .waddr_i (ins_r[6:0]),
        .wdata_i (ram_wdata),
        .rdata_o (ram_rdata)
    );

    nmt_nibble_mem #(
        .DEPTH (WR_DEPTH),
        .AW    (WS_W)
    ) u_wreg (
        .mclk_i  (mclk_i),
        .ce_i    (ce_i),
        .rd_i    (take),
        .raddr_i (instr_i[10:7]),
        .we_i    (wr_we),
        .waddr_i (wr_waddr),
        .wdata_i (wr_wdata),
        .rdata_o (wr_rdata)
    );

    nmt_change_flags u_flags (
        .mclk_i              (mclk_i),
        .reset_i             (reset_i),
        .ce_i                (ce_i),
        .change_sense_port_i (change_sense_port_i),
        .clear_i             (irq_clr),
        .port_change_flags_o (flags)
    );

    // Write-back decode
    always_comb begin
        ram_we    = 1'b0;
        ram_wdata = ram_rdata;
        wr_we     = 1'b0;
        wr_waddr  = ins_r[10:7];
        wr_wdata  = ram_rdata;
        acc_we    = 1'b0;
        acc_wdata = accumulator_o;
        if (state_r == NMT_ST_EXEC) begin
            case (op_r)
                NMT_OP_READ_FLAGS: begin
                    ram_we    = 1'b1;
                    ram_wdata = flags;
                    acc_we    = 1'b1;
                    acc_wdata = flags;
                end
                NMT_OP_W_TO_M: begin
                    ram_we    = 1'b1;
                    ram_wdata = wr_rdata;
                    acc_we    = 1'b1;
                    acc_wdata = wr_rdata;
                end
                NMT_OP_M_TO_W: begin
                    wr_we     = 1'b1;
                    acc_we    = 1'b1;
                    acc_wdata = ram_rdata;
                end
                NMT_OP_OR_ACC: begin
                    acc_we    = 1'b1;
                    acc_wdata = ram_rdata | accumulator_o;
                end
                default: begin
                    acc_we = 1'b0;
                end
            endcase
        end else if (state_r == NMT_ST_TBL_B) begin
            // Pointer form lands in RAM; immediate form in a working register
            if (op_r == NMT_OP_PTR_READ) begin
                ram_we    = 1'b1;
                ram_wdata = rom_data_i;
            end else begin
                wr_we    = 1'b1;
                wr_wdata = rom_data_i;
            end
        end
    end

    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            accumulator_o <= RST_NIBBLE;
            zero_flag_o   <= RST_ZF;
        end else if (ce_i && acc_we) begin
            accumulator_o <= acc_wdata;
            zero_flag_o   <= (acc_wdata == 4'h0);
        end
    end

    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            table_pointer_low_o  <= RST_NIBBLE;
            table_pointer_high_o <= RST_NIBBLE;
        end else if (ce_i && state_r == NMT_ST_EXEC) begin
            if (op_r == NMT_OP_LOAD_LOW) begin
                table_pointer_low_o <= ram_rdata;
            end
            if (op_r == NMT_OP_LOAD_HIGH) begin
                table_pointer_high_o <= ram_rdata;
            end
        end
    end

    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            instr_done_o <= 1'b0;
        end else if (ce_i) begin
            instr_done_o <= (state_nxt == NMT_ST_IDLE) && (state_r != NMT_ST_IDLE);
        end
    end

    // Register port
    assign irq_clr = (ce_i && reg_wr_i && reg_addr_i == REG_IRQ_CLR) ? reg_wdata_i[3:0] : 4'h0;
    assign irq_o   = |(flags & irq_en_r);

    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            irq_en_r <= RST_IRQ_EN;
            run_r    <= RST_RUN;
        end else if (ce_i && reg_wr_i) begin
            if (reg_addr_i == REG_IRQ_EN) begin
                irq_en_r <= reg_wdata_i[3:0];
            end
            if (reg_addr_i == REG_CTRL) begin
                run_r <= reg_wdata_i[CTRL_RUN_BIT];
            end
        end
    end

    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            reg_rdata_o <= '0;
        end else if (ce_i) begin
            reg_rdata_o <= '0;
            if (reg_rd_i) begin
                case (reg_addr_i)
                    REG_STATUS: reg_rdata_o <= {12'h000, flags};
                    REG_IRQ_EN: reg_rdata_o <= {12'h000, irq_en_r};
                    REG_CORE:   reg_rdata_o <= {3'h0, zero_flag_o, table_pointer_high_o,
                                                table_pointer_low_o, accumulator_o};
                    REG_CTRL:   reg_rdata_o <= {15'h0000, run_r};
                    default:    reg_rdata_o <= '0;
                endcase
            end
        end
    end

    // Checks
    a_flags_copy: assert property (@(posedge mclk_i) disable iff (reset_i)
        (ce_i && state_r == NMT_ST_EXEC && op_r == NMT_OP_READ_FLAGS)
        |-> (ram_we && ram_wdata == flags) ##1 (accumulator_o == $past(flags)))
        else $error("port flags not copied");
    a_w_to_m_move: assert property (@(posedge mclk_i) disable iff (reset_i)
        (ce_i && state_r == NMT_ST_EXEC && op_r == NMT_OP_W_TO_M)
        |-> ram_we && ram_wdata == wr_rdata && !wr_we)
        else $error("working register not written to RAM");
    a_m_to_w_move: assert property (@(posedge mclk_i) disable iff (reset_i)
        (ce_i && state_r == NMT_ST_EXEC && op_r == NMT_OP_M_TO_W)
        |-> wr_we && wr_wdata == ram_rdata && !ram_we ##1 accumulator_o == $past(ram_rdata))
        else $error("RAM not moved to working register");
    a_ptr_low_load: assert property (@(posedge mclk_i) disable iff (reset_i)
        (ce_i && state_r == NMT_ST_EXEC && op_r == NMT_OP_LOAD_LOW)
        |=> table_pointer_low_o == $past(ram_rdata) && $stable(zero_flag_o))
        else $error("low pointer load wrong");
    a_ptr_high_load: assert property (@(posedge mclk_i) disable iff (reset_i)
        (ce_i && state_r == NMT_ST_EXEC && op_r == NMT_OP_LOAD_HIGH)
        |=> table_pointer_high_o == $past(ram_rdata) && $stable(zero_flag_o))
        else $error("high pointer load wrong");
    a_ptr_rom_addr: assert property (@(posedge mclk_i) disable iff (reset_i)
        (ce_i && state_r == NMT_ST_EXEC && op_r == NMT_OP_PTR_READ)
        |=> rom_rd_o && rom_addr_o == {3'h0, $past(table_pointer_high_o),
                                       $past(table_pointer_low_o)})
        else $error("pointer ROM address wrong");
    a_table_length: assert property (@(posedge mclk_i) disable iff (reset_i)
        (take && instr_i[15:11] == OPC_IMM_READ) ##1 ce_i [*3]
        |-> state_r == NMT_ST_TBL_B && wr_we && wr_wdata == rom_data_i)
        else $error("immediate table read not four clocks");
    a_or_keeps_ram: assert property (@(posedge mclk_i) disable iff (reset_i)
        (ce_i && state_r == NMT_ST_EXEC && op_r == NMT_OP_OR_ACC)
        |-> !ram_we ##1 accumulator_o == ($past(ram_rdata) | $past(accumulator_o)))
        else $error("OR result wrong or RAM written");
    a_direct_addr: assert property (@(posedge mclk_i) disable iff (reset_i)
        take |=> ins_r[6:0] == $past(instr_i[6:0]))
        else $error("RAM address not from instruction");
    a_idle_quiet: assert property (@(posedge mclk_i) disable iff (reset_i)
        (state_r == NMT_ST_EXEC && op_r == NMT_OP_IDLE) |-> !ram_we && !wr_we && !acc_we)
        else $error("idle code changed state");
    a_zero_flag: assert property (@(posedge mclk_i) disable iff (reset_i)
        (ce_i && acc_we) |=> zero_flag_o == (accumulator_o == 4'h0))
        else $error("zero flag does not follow accumulator");

    c_ptr_read: cover property (@(posedge mclk_i) disable iff (reset_i)
        state_r == NMT_ST_TBL_B && op_r == NMT_OP_PTR_READ);
    c_imm_read: cover property (@(posedge mclk_i) disable iff (reset_i)
        state_r == NMT_ST_TBL_B && op_r == NMT_OP_IMM_READ);
    c_or_zero: cover property (@(posedge mclk_i) disable iff (reset_i)
        state_r == NMT_ST_EXEC && op_r == NMT_OP_OR_ACC ##1 zero_flag_o);
    c_irq: cover property (@(posedge mclk_i) disable iff (reset_i) irq_o);
endmodule // nmt_exec
`default_nettype wire

// >>> verif/testbench.sv
// Self-checking bench for the nibble move and table read executor
`default_nettype none
module testbench
    import nmt_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic              mclk_i, reset_i, ce_i, instr_valid_i, reg_wr_i, reg_rd_i;
    logic [15:0]       instr_i, reg_wdata_i, ins;
    logic [NW_W-1:0]   rom_data_i, change_sense_port_i;
    logic [REG_AW-1:0] reg_addr_i;
    logic              instr_ready_o, instr_done_o, rom_rd_o, zero_flag_o, irq_o;
    logic [ROM_AW-1:0] rom_addr_o;
    logic [NW_W-1:0]   accumulator_o, table_pointer_low_o, table_pointer_high_o;
    logic [REG_DW-1:0] reg_rdata_o;
    int                num_errors = 0;
    int                total_checks = 0;
    logic [31:0]       seed = 32'hb178;
    logic [3:0]        ram_m [RAM_DEPTH];
    logic [3:0]        wr_m [WR_DEPTH];
    logic [3:0]        acc_m = 4'h0, tl_m = 4'h0, th_m = 4'h0, flg_m = 4'h0, en_m;
    logic              zf_m = 1'b0;

    initial begin
        mclk_i = 1'b0;
        forever #20 mclk_i = ~mclk_i;
    end

    nmt_exec uut (
        .mclk_i(mclk_i), .reset_i(reset_i), .ce_i(ce_i), .instr_i(instr_i),
        .instr_valid_i(instr_valid_i), .instr_ready_o(instr_ready_o),
        .instr_done_o(instr_done_o), .rom_addr_o(rom_addr_o), .rom_rd_o(rom_rd_o),
        .rom_data_i(rom_data_i), .change_sense_port_i(change_sense_port_i),
        .accumulator_o(accumulator_o), .zero_flag_o(zero_flag_o),
        .table_pointer_low_o(table_pointer_low_o),
        .table_pointer_high_o(table_pointer_high_o), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .irq_o(irq_o)
    );

    function automatic logic [31:0] rnd();
        seed = seed[0] ? ((seed >> 1) ^ 32'h80200003) : (seed >> 1);
        return seed;
    endfunction

    task automatic chk_val(input string nm, input logic [15:0] e, input logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic reg_wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge mclk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge mclk_i);
        reg_wr_i <= 1'b0;
    endtask

    // Read data is only good in the cycle after the strobe
    task automatic reg_chk(input string nm, input logic [2:0] a, input logic [15:0] e);
        @(posedge mclk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge mclk_i);
        reg_rd_i <= 1'b0;
        @(negedge mclk_i);
        chk_val(nm, e, reg_rdata_o);
        @(negedge mclk_i);
        chk_val("rdata_idle", 16'h0000, reg_rdata_o);
    endtask

    task automatic put(input logic [3:0] v);
        acc_m = v;
        zf_m = (v == 4'h0);
    endtask

    task automatic do_op(input logic [15:0] i, input logic [3:0] d);
        logic [6:0]  a;
        logic [3:0]  w;
        logic [10:0] ea;
        logic        tbl;
        logic        seen;
        int          n;
        a = i[6:0];
        w = i[10:7];
        tbl = (i[15:7] == OPC_PTR_READ) || (i[15:11] == OPC_IMM_READ);
        ea = (i[15:7] == OPC_PTR_READ) ? {3'h0, th_m, tl_m} : {i[6:0], acc_m};
        seen = 1'b0;
        if (i[15:7] == OPC_READ_FLAGS) begin
            put(flg_m);
            ram_m[a] = flg_m;
        end else if (i[15:7] == OPC_LOAD_LOW) tl_m = ram_m[a];
        else if (i[15:7] == OPC_LOAD_HIGH) th_m = ram_m[a];
        else if (i[15:7] == OPC_PTR_READ) ram_m[a] = d;
        else if (i[15:7] == OPC_OR_ACC) put(acc_m | ram_m[a]);
        else if (i[15:12] == OPC_W_TO_M) begin
            put(wr_m[w]);
            ram_m[a] = wr_m[w];
        end else if (i[15:11] == OPC_M_TO_W) begin
            put(ram_m[a]);
            wr_m[w] = ram_m[a];
        end else if (i[15:11] == OPC_IMM_READ) wr_m[w] = d;
        @(posedge mclk_i);
        instr_i <= i;
        instr_valid_i <= 1'b1;
        rom_data_i <= ~d;
        n = 0;
        do begin
            @(negedge mclk_i);
            n++;
        end while (instr_ready_o !== 1'b1 && n < 20);
        if (instr_ready_o !== 1'b1) begin
            num_errors++;
            finish_test();
        end
        @(posedge mclk_i);
        instr_valid_i <= 1'b0;
        instr_i <= ~i;
        for (n = 1; n <= 8; n++) begin
            @(negedge mclk_i);
            if (instr_done_o === 1'b1) break;
            if (rom_rd_o === 1'b1) begin
                seen = 1'b1;
                chk_val("rom_addr", 16'(ea), 16'(rom_addr_o));
                @(posedge mclk_i);
                rom_data_i <= d;
            end
        end
        chk_val("latency", tbl ? 16'h4 : 16'h2, 16'(n));
        if (n > 8) finish_test();
        chk_val("rom_read", 16'(tbl), 16'(seen));
        chk_val("acc", 16'(acc_m), 16'(accumulator_o));
        chk_val("zf", 16'(zf_m), 16'(zero_flag_o));
        chk_val("table_pointer_low", 16'(tl_m), 16'(table_pointer_low_o));
        chk_val("table_pointer_high", 16'(th_m), 16'(table_pointer_high_o));
    endtask

    initial begin
        logic [31:0] r;
        logic [3:0]  v;
        reset_i = 1'b1;
        ce_i = 1'b1;
        instr_i = 16'h0000;
        instr_valid_i = 1'b0;
        rom_data_i = 4'h0;
        change_sense_port_i = 4'h0;
        reg_addr_i = 3'h0;
        reg_wdata_i = 16'h0000;
        reg_wr_i = 1'b0;
        reg_rd_i = 1'b0;
        repeat (3) @(posedge mclk_i);
        reset_i <= 1'b0;
        reg_chk("core_rst", REG_CORE, 16'h0000);
        reg_chk("en_rst", REG_IRQ_EN, 16'h0000);
        reg_chk("ctrl_rst", REG_CTRL, 16'h0001);
        reg_chk("unmapped", 3'h7, 16'h0000);
        $display("test reset done");
        // Working registers and RAM power up unknown, so load them all first
        for (int w = 0; w < WR_DEPTH; w++) begin
            r = rnd();
            do_op({OPC_IMM_READ, 4'(w), r[6:0]}, (w == 0) ? 4'h0 : r[10:7]);
        end
        for (int a = 0; a < RAM_DEPTH; a++) begin
            r = rnd();
            do_op({OPC_W_TO_M, r[0], 4'(a), 7'(a)}, 4'h0);
        end
        do_op(OPC_IDLE, 4'h5);
        do_op(16'hffff, 4'ha);
        $display("test fill done");
        for (int k = 0; k < 300; k++) begin
            r = rnd();
            case (r[2:0])
                3'h0: ins = {OPC_M_TO_W, r[6:3], r[13:7]};
                3'h1: ins = {OPC_W_TO_M, r[3], r[7:4], r[14:8]};
                3'h2: ins = {OPC_LOAD_LOW, r[9:3]};
                3'h3: ins = {OPC_LOAD_HIGH, r[9:3]};
                3'h4: ins = {OPC_PTR_READ, r[9:3]};
                3'h5: ins = {OPC_IMM_READ, r[6:3], r[13:7]};
                3'h6: ins = {OPC_OR_ACC, r[9:3]};
                default: ins = {OPC_READ_FLAGS, r[9:3]};
            endcase
            do_op(ins, r[19:16]);
        end
        $display("test random done");
        for (int k = 0; k < 5; k++) begin
            r = rnd();
            v = (k == 0) ? 4'h5 : r[3:0];
            en_m = r[14:11];
            reg_wr(REG_IRQ_EN, 16'(en_m));
            change_sense_port_i <= change_sense_port_i ^ v;
            flg_m = flg_m | v;
            repeat (5) @(posedge mclk_i);
            reg_chk("status", REG_STATUS, 16'(flg_m));
            chk_val("irq", 16'((flg_m & en_m) != 4'h0), 16'(irq_o));
            do_op({OPC_READ_FLAGS, r[10:4]}, 4'h0);
            do_op({OPC_M_TO_W, 4'h3, r[10:4]}, 4'h0);
        end
        reg_wr(REG_IRQ_CLR, 16'(flg_m));
        flg_m = 4'h0;
        reg_chk("status_clr", REG_STATUS, 16'h0000);
        chk_val("irq_clr", 16'h0000, 16'(irq_o));
        do_op({OPC_READ_FLAGS, 7'h7f}, 4'h0);
        // Corner: a pin change landing on the clear edge must survive
        @(posedge mclk_i);
        change_sense_port_i <= change_sense_port_i ^ 4'h1;
        @(posedge mclk_i);
        reg_wr(REG_IRQ_CLR, 16'h000f);
        flg_m = 4'h1;
        reg_chk("status_race", REG_STATUS, 16'(flg_m));
        $display("test flags done");
        reg_wr(REG_CTRL, 16'h0000);
        @(negedge mclk_i);
        chk_val("ready_stop", 16'h0000, 16'(instr_ready_o));
        reg_wr(REG_CTRL, 16'h0001);
        ce_i <= 1'b0;
        @(negedge mclk_i);
        chk_val("ready_ce", 16'h0000, 16'(instr_ready_o));
        @(posedge mclk_i);
        ce_i <= 1'b1;
        @(negedge mclk_i);
        chk_val("ready_run", 16'h0001, 16'(instr_ready_o));
        reg_chk("core", REG_CORE, {3'h0, zf_m, th_m, tl_m, acc_m});
        $display("test control done");
        finish_test();
    end
endmodule // testbench
`default_nettype wire
